/* design/dcs_consts.svh */
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH
// Register addresses on the 7-bit host address bus
`define DCS_ADDR_CONTROL 7'h78
`define DCS_ADDR_ROUTING 7'h79
`define DCS_ADDR_UNUSED_A 7'h7A
`define DCS_ADDR_UNUSED_B 7'h7B
`define DCS_ADDR_UNUSED_C 7'h7C
`define DCS_ADDR_SIGREV 7'h7D
`define DCS_ADDR_STATUS 7'h7E
`define DCS_ADDR_ACTION 7'h7F
// Reset values
`define DCS_RESET_WORD 16'h0000
// Field positions
`define DCS_CTRL_TEST_BIT 14
`define DCS_SIG_VALID_BIT 15
`define DCS_SIG_HI 14
`define DCS_SIG_LO 3
`define DCS_STAT_CH_LO 12
`define DCS_STAT_OUT_BIT 11
`define DCS_SUMMARY_MASK 16'hF800
`define DCS_SAT_MASK 16'h03FF
`define DCS_ACT_RESET_BIT 1
`define DCS_ACT_SYNC_BIT 0
// Channel status bits that feed a channel summary: 10:7 and 3
`define DCS_CH_FAULT_MASK 16'h0788
// Revision code, value arbitrary
`define DCS_REVISION 3'h5
// Self-test length in core clocks
`define DCS_BIST_CYCLES 8'h40
// Data width of saturating summers
`define DCS_SUM_W 20
`endif

/* design/dcs_pkg.sv */
package dcs_pkg;
  typedef enum logic [1:0] {DCS_BIST_IDLE, DCS_BIST_RUN, DCS_BIST_DONE} dcs_bist_state_t;
  typedef logic [15:0] dcs_word_t;
endpackage

/* design/dcs_sat_clamp.sv */
`timescale 1ns/1ps
`include "dcs_consts.svh"
// Saturating adder: clamps to most positive or most negative plus one
module dcs_sat_clamp
(
  input wire logic signed [`DCS_SUM_W-1:0] a_in, // Operand a
  input wire logic signed [`DCS_SUM_W-1:0] b_in, // Operand b
  output logic signed [`DCS_SUM_W-1:0] sum_out, // Clamped sum
  output logic sat_out // Overflow seen
);
  logic signed [`DCS_SUM_W:0] wide;

  // Extended sum and clamp on overflow
  always_comb
  begin
    wide = {a_in[`DCS_SUM_W-1], a_in} + {b_in[`DCS_SUM_W-1], b_in};
    sat_out = wide[`DCS_SUM_W] != wide[`DCS_SUM_W-1];
    if (!sat_out)
      sum_out = wide[`DCS_SUM_W-1:0];
    else if (wide[`DCS_SUM_W])
      sum_out = {1'b1, {(`DCS_SUM_W-2){1'b0}}, 1'b1};
    else
      sum_out = {1'b0, {(`DCS_SUM_W-1){1'b1}}};
  end
endmodule // dcs_sat_clamp

/* design/dcs_bank.sv */
`timescale 1ns/1ps
`include "dcs_consts.svh"
// Notes on behaviour
// - The self-test valid flag clears when control bit 14 toggles and sets when self-test completes.
// - The self-test signature appears in bits 14:3 of the signature word, trustworthy only when valid.
// - Channel summary bits 15:12 are the OR of channel status bits 10:7 and 3.
// - Writing one to status bits 15:11 clears those summary bits, and bit 11 also clears flags 9:0.
// - Clearing a channel summary also clears that channel's status word.
// - Bit 11 rises on any saturation and clearing it clears flags 9:0.
// - Flags: bit 9 cascade I, bit 8 cascade Q, bits 7:0 I/Q pairs for summers 4 to 1, bit 10 unused.
// - Overflowing summer or cascade data clamps to most positive or most negative plus one and flags it.
// - Action bit 1 issues a self-clearing hard reset that restores the configuration, self-test and status registers, not the registered outputs.
// - Action bit 0 issues a self-clearing sync-out pulse.
// - Control and routing words are read/write, reset to zero, routing applied by the update strobe.
// - The action word is write-only with no readable copy and 0x7A to 0x7C are unused.
// - Each configuration register has a master copy and a slave copy, reads return the slave.
// - Slave copies clear on hard or soft reset, masters only on hard reset.
module dcs_bank
(
  input wire logic clk_sys_in, // Core clock, 20 MHz
  input wire logic reset_in, // Hard reset, sync, active high
  input wire logic soft_reset_in, // Soft reset, clears slave copies
  input wire logic cs_n_in, // Chip select, active low
  input wire logic wr_in, // Write strobe, one cycle per write
  input wire logic rd_in, // Read strobe
  input wire logic [6:0] addr_in, // Register address
  input wire logic [15:0] data_in, // Host write data
  input wire logic update_in, // Update strobe for routing word
  input wire logic [63:0] ch_status_in, // Four channel status words, ch0 low
  input wire logic bist_done_in, // Self-test finished
  input wire logic [11:0] bist_sig_in, // Self-test signature
  input wire logic [8*`DCS_SUM_W-1:0] sum_a_in, // Operand a per lane, lane 2k+1 summer k+1 I, lane 2k its Q
  input wire logic [8*`DCS_SUM_W-1:0] sum_b_in, // Operand b per lane, same lane order
  input wire logic [`DCS_SUM_W-1:0] casc_i_a_in, // Cascade I operand a
  input wire logic [`DCS_SUM_W-1:0] casc_i_b_in, // Cascade I operand b
  input wire logic [`DCS_SUM_W-1:0] casc_q_a_in, // Cascade Q operand a
  input wire logic [`DCS_SUM_W-1:0] casc_q_b_in, // Cascade Q operand b
  output logic [15:0] data_out, // Read data
  output logic data_oe_n_out, // Data bus enable, low while driving
  output logic [15:0] control_out, // Device control slave copy
  output logic [15:0] routing_out, // Routing slave copy
  output logic [3:0] ch_clear_out, // Per-channel status clear pulse
  output logic hard_reset_out, // Self-clearing hard reset pulse
  output logic sync_out, // Self-clearing sync-out pulse
  output logic [8*`DCS_SUM_W-1:0] sum_out, // Clamped summer lanes
  output logic [`DCS_SUM_W-1:0] casc_i_out, // Clamped cascade I
  output logic [`DCS_SUM_W-1:0] casc_q_out // Clamped cascade Q
);
  dcs_pkg::dcs_word_t ctrl_m_r, ctrl_m_nxt, rout_m_r, rout_m_nxt;
  dcs_pkg::dcs_word_t ctrl_s_r, ctrl_s_nxt, rout_s_r, rout_s_nxt;
  dcs_pkg::dcs_word_t stat_r, stat_nxt, dout_r, dout_nxt;
  logic oe_n_r, oe_n_nxt, hrst_r, hrst_nxt, sync_r, sync_nxt;
  logic [3:0] chclr_r, chclr_nxt;
  logic valid_r, valid_nxt, test_q_r, test_q_nxt;
  logic [11:0] sig_r, sig_nxt;
  logic [7:0] bcnt_r, bcnt_nxt;
  dcs_pkg::dcs_bist_state_t bst_r, bst_nxt;
  logic [8*`DCS_SUM_W-1:0] sum_c, sum_r;
  logic [`DCS_SUM_W-1:0] ci_c, cq_c, ci_r, cq_r;
  logic [9:0] sat_c;
  logic wr_hit, rd_hit, any_rst, hard_rst;
  logic [3:0] ch_fault;

  // Host access decode
  assign wr_hit = wr_in && !cs_n_in;
  assign rd_hit = rd_in && !cs_n_in;
  assign hard_rst = reset_in || hrst_r;
  assign any_rst = hard_rst || soft_reset_in;

  // Saturating output summers, one clamp per lane; lane k raises flag k, so I and Q flag apart
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_sum
      dcs_sat_clamp u_lane
      (
        .a_in(sum_a_in[g*`DCS_SUM_W+:`DCS_SUM_W]),
        .b_in(sum_b_in[g*`DCS_SUM_W+:`DCS_SUM_W]),
        .sum_out(sum_c[g*`DCS_SUM_W+:`DCS_SUM_W]),
        .sat_out(sat_c[g])
      );
    end
    for (g = 0; g < 4; g = g + 1)
    begin : g_ch
      assign ch_fault[g] = |(ch_status_in[16*g+:16] & `DCS_CH_FAULT_MASK);
    end
  endgenerate

  // Cascade path saturation
  dcs_sat_clamp u_ci
  (
    .a_in(casc_i_a_in),
    .b_in(casc_i_b_in),
    .sum_out(ci_c),
    .sat_out(sat_c[9])
  );
  dcs_sat_clamp u_cq
  (
    .a_in(casc_q_a_in),
    .b_in(casc_q_b_in),
    .sum_out(cq_c),
    .sat_out(sat_c[8])
  );

  // Master copies, written by host strobe, cleared only by hard reset
  always_comb
  begin
    ctrl_m_nxt = ctrl_m_r;
    rout_m_nxt = rout_m_r;
    if (wr_hit && addr_in == `DCS_ADDR_CONTROL)
      ctrl_m_nxt = data_in;
    if (wr_hit && addr_in == `DCS_ADDR_ROUTING)
      rout_m_nxt = data_in;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (hard_rst)
    begin
      ctrl_m_r <= `DCS_RESET_WORD;
      rout_m_r <= `DCS_RESET_WORD;
    end
    else
    begin
      ctrl_m_r <= ctrl_m_nxt;
      rout_m_r <= rout_m_nxt;
    end
  end

  // Slave copies on core clock; routing waits for update strobe
  always_comb
  begin
    ctrl_s_nxt = ctrl_m_r;
    rout_s_nxt = update_in ? rout_m_r : rout_s_r;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (any_rst)
    begin
      ctrl_s_r <= `DCS_RESET_WORD;
      rout_s_r <= `DCS_RESET_WORD;
    end
    else
    begin
      ctrl_s_r <= ctrl_s_nxt;
      rout_s_r <= rout_s_nxt;
    end
  end

  // Self-test sequencer and valid flag
  always_comb
  begin
    bst_nxt = bst_r;
    bcnt_nxt = bcnt_r;
    valid_nxt = valid_r;
    sig_nxt = sig_r;
    test_q_nxt = ctrl_s_r[`DCS_CTRL_TEST_BIT];
    case (bst_r)
      dcs_pkg::DCS_BIST_IDLE:
      begin
        if (test_q_r != ctrl_s_r[`DCS_CTRL_TEST_BIT])
        begin
          valid_nxt = 1'b0;
          bcnt_nxt = `DCS_BIST_CYCLES;
          bst_nxt = dcs_pkg::DCS_BIST_RUN;
        end
      end
      dcs_pkg::DCS_BIST_RUN:
      begin
        bcnt_nxt = bcnt_r - 8'h01;
        if (test_q_r != ctrl_s_r[`DCS_CTRL_TEST_BIT])
        begin
          valid_nxt = 1'b0;
          bcnt_nxt = `DCS_BIST_CYCLES;
        end
        else if (bist_done_in || bcnt_r == 8'h00)
          bst_nxt = dcs_pkg::DCS_BIST_DONE;
      end
      dcs_pkg::DCS_BIST_DONE:
      begin
        valid_nxt = 1'b1;
        sig_nxt = bist_sig_in;
        bst_nxt = dcs_pkg::DCS_BIST_IDLE;
        // A toggle landing on the completion cycle must not be lost
        if (test_q_r != ctrl_s_r[`DCS_CTRL_TEST_BIT])
        begin
          valid_nxt = 1'b0;
          bcnt_nxt = `DCS_BIST_CYCLES;
          bst_nxt = dcs_pkg::DCS_BIST_RUN;
        end
      end
      default:
        bst_nxt = dcs_pkg::DCS_BIST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (any_rst)
    begin
      bst_r <= dcs_pkg::DCS_BIST_IDLE;
      bcnt_r <= 8'h00;
      valid_r <= 1'b0;
      sig_r <= 12'h000;
      test_q_r <= 1'b0;
    end
    else
    begin
      bst_r <= bst_nxt;
      bcnt_r <= bcnt_nxt;
      valid_r <= valid_nxt;
      sig_r <= sig_nxt;
      test_q_r <= test_q_nxt;
    end
  end

  // Fault status: sticky sets win over host clears
  always_comb
  begin
    stat_nxt = stat_r;
    chclr_nxt = 4'h0;
    if (wr_hit && addr_in == `DCS_ADDR_STATUS)
    begin
      stat_nxt = stat_r & ~(data_in & `DCS_SUMMARY_MASK);
      chclr_nxt = data_in[15:12];
      if (data_in[`DCS_STAT_OUT_BIT])
        stat_nxt = stat_nxt & ~`DCS_SAT_MASK;
    end
    stat_nxt[15:12] = stat_nxt[15:12] | ch_fault;
    stat_nxt[9:0] = stat_nxt[9:0] | sat_c;
    stat_nxt[`DCS_STAT_OUT_BIT] = stat_nxt[`DCS_STAT_OUT_BIT] | (|sat_c);
    stat_nxt[10] = 1'b0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (any_rst)
    begin
      stat_r <= `DCS_RESET_WORD;
      chclr_r <= 4'h0;
    end
    else
    begin
      stat_r <= stat_nxt;
      chclr_r <= chclr_nxt;
    end
  end

  // Immediate action pulses; reserved bits ignored
  always_comb
  begin
    hrst_nxt = 1'b0;
    sync_nxt = 1'b0;
    if (wr_hit && addr_in == `DCS_ADDR_ACTION)
    begin
      hrst_nxt = data_in[`DCS_ACT_RESET_BIT];
      sync_nxt = data_in[`DCS_ACT_SYNC_BIT];
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || hrst_r)
    begin
      hrst_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      hrst_r <= hrst_nxt;
      sync_r <= sync_nxt;
    end
  end

  // Read mux returns slave copies
  always_comb
  begin
    oe_n_nxt = !rd_hit;
    case (addr_in)
      `DCS_ADDR_CONTROL: dout_nxt = ctrl_s_r;
      `DCS_ADDR_ROUTING: dout_nxt = rout_s_r;
      `DCS_ADDR_SIGREV: dout_nxt = {valid_r, sig_r, `DCS_REVISION};
      `DCS_ADDR_STATUS: dout_nxt = stat_r;
      default: dout_nxt = 16'h0000;
    endcase
    if (!rd_hit)
      dout_nxt = 16'h0000;
  end

  // Registered outputs, summer data included
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      dout_r <= 16'h0000;
      oe_n_r <= 1'b1;
      sum_r <= '0;
      ci_r <= '0;
      cq_r <= '0;
    end
    else
    begin
      dout_r <= dout_nxt;
      oe_n_r <= oe_n_nxt;
      sum_r <= sum_c;
      ci_r <= ci_c;
      cq_r <= cq_c;
    end
  end

  assign data_out = dout_r;
  assign data_oe_n_out = oe_n_r;
  assign control_out = ctrl_s_r;
  assign routing_out = rout_s_r;
  assign ch_clear_out = chclr_r;
  assign hard_reset_out = hrst_r;
  assign sync_out = sync_r;
  assign sum_out = sum_r;
  assign casc_i_out = ci_r;
  assign casc_q_out = cq_r;
endmodule // dcs_bank

/* bench/dcs_bank_asserts.sv */
`timescale 1ns/1ps
// Port checker for the device control bank
module dcs_bank_chk
(
  input wire logic clk_sys_in, // Clock
  input wire logic reset_in, // Hard reset
  input wire logic cs_n_in, // Select
  input wire logic wr_in, // Write
  input wire logic rd_in, // Read
  input wire logic [6:0] addr_in, // Address
  input wire logic [15:0] data_in, // Write data
  input wire logic [15:0] data_out, // Read data
  input wire logic data_oe_n_out, // Bus enable
  input wire logic [15:0] control_out, // Control slave
  input wire logic [15:0] routing_out, // Routing slave
  input wire logic [3:0] ch_clear_out, // Channel clears
  input wire logic hard_reset_out, // Reset pulse
  input wire logic sync_out // Sync pulse
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // Accesses decoded from the port
  sequence s_rd;
    rd_in && !cs_n_in;
  endsequence
  sequence s_act(int b);
    wr_in && !cs_n_in && addr_in == 7'h7F && data_in[b];
  endsequence
  a_read_drive: assert property (s_rd |=> !data_oe_n_out) else $error("bus not driven on read");
  a_bus_release: assert property (!(rd_in && !cs_n_in) |=> data_oe_n_out) else $error("bus driven idle");
  a_read_slave: assert property (s_rd ##0 addr_in == 7'h78 |=> data_out == $past(control_out))
    else $error("read not slave copy");
  a_ctrl_write: assert property (wr_in && !cs_n_in && addr_in == 7'h78 |-> ##2 control_out == $past(data_in, 2))
    else $error("control write lost");
  a_sync_pulse: assert property (s_act(0) |=> sync_out ##1 !sync_out) else $error("sync pulse wrong");
  a_hard_pulse: assert property (s_act(1) |=> hard_reset_out ##1 !hard_reset_out) else $error("reset pulse wrong");
  a_no_stray_sync: assert property (sync_out |-> $past(wr_in && !cs_n_in && addr_in == 7'h7F && data_in[0]))
    else $error("stray sync");
  a_ch_clear: assert property (wr_in && !cs_n_in && addr_in == 7'h7E |=> ch_clear_out == $past(data_in[15:12]))
    else $error("channel clear wrong");
  a_hard_clears: assert property (hard_reset_out |-> ##[1:2] control_out == 16'h0000 && routing_out == 16'h0000)
    else $error("hard reset kept regs");
endmodule // dcs_bank_chk
bind dcs_bank dcs_bank_chk chk (.clk_sys_in, .reset_in, .cs_n_in, .wr_in, .rd_in, .addr_in, .data_in, .data_out,
  .data_oe_n_out, .control_out, .routing_out, .ch_clear_out, .hard_reset_out, .sync_out);

/* bench/dcs_host_model.sv */
`timescale 1ns/1ps
// Host processor on the parallel register port
module dcs_host_model
(
  input wire logic clk_in, // Clock
  input wire logic [15:0] rdata_in, // Read data
  output logic cs_n_out, // Select
  output logic wr_out, // Write
  output logic rd_out, // Read
  output logic [6:0] addr_out, // Address
  output logic [15:0] data_out // Write data
);
  // Idle bus at time zero
  initial
  begin
    cs_n_out = 1'b1;
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 7'h00;
    data_out = 16'h0000;
  end
  // One write, then settle time before reusing an address
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    wr_out <= 1'b1;
    addr_out <= a;
    data_out <= (a == 7'h7F) ? (d & 16'h0003) : d;
    @(posedge clk_in);
    cs_n_out <= 1'b1;
    wr_out <= 1'b0;
    data_out <= ~d; // Released data shows no stale value
    repeat (4) @(posedge clk_in);
  endtask
  // One read, data taken at the edge after the sampling edge
  task automatic rd(input logic [6:0] a, output logic [15:0] q);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    rd_out <= 1'b1;
    addr_out <= a;
    repeat (2) @(posedge clk_in);
    q = rdata_in;
    cs_n_out <= 1'b1;
    rd_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
endmodule // dcs_host_model

/* bench/dcs_bank_tb.sv */
`timescale 1ns/1ps
`include "dcs_consts.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("MISMATCH t=%0t %h %h", $time, a, b); end end
module dcs_bank_tb;
  logic clk_sys_in, reset_in, soft_reset_in, cs_n_in, wr_in, rd_in, update_in, bist_done_in, data_oe_n_out;
  logic hard_reset_out, sync_out;
  logic [6:0] addr_in;
  logic [15:0] data_in, data_out, control_out, routing_out, q;
  logic [3:0] clr_acc = 4'h0;
  logic [63:0] ch_status_in;
  logic [11:0] bist_sig_in;
  logic [159:0] sum_a_in, sum_b_in, sum_out;
  logic [19:0] casc_i_a_in, casc_i_b_in, casc_q_a_in, casc_q_b_in, casc_i_out, casc_q_out;
  logic [3:0] ch_clear_out;
  int mdl[int];
  int fails, samples_checked, n, ch;
  int unsigned seed = 99;
  dcs_bank uut (.clk_sys_in, .reset_in, .soft_reset_in, .cs_n_in, .wr_in, .rd_in, .addr_in, .data_in, .update_in,
    .ch_status_in, .bist_done_in, .bist_sig_in, .sum_a_in, .sum_b_in, .casc_i_a_in, .casc_i_b_in, .casc_q_a_in,
    .casc_q_b_in, .data_out, .data_oe_n_out, .control_out, .routing_out, .ch_clear_out, .hard_reset_out,
    .sync_out, .sum_out, .casc_i_out, .casc_q_out);
  dcs_host_model host (.clk_in(clk_sys_in), .rdata_in(data_out), .cs_n_out(cs_n_in), .wr_out(wr_in),
    .rd_out(rd_in), .addr_out(addr_in), .data_out(data_in));
  // Core clock, 50 ns period
  initial
  begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  // Sync pulse count and last channel clear pulse seen
  always @(posedge clk_sys_in)
  begin
    if (sync_out === 1'b1) n++;
    if (ch_clear_out != 4'h0) clr_acc <= ch_clear_out;
  end
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // One-cycle pulse on update, soft reset or self-test done, in that bit order
  task automatic pulse(input logic [2:0] w);
    @(posedge clk_sys_in) {update_in, soft_reset_in, bist_done_in} <= w;
    @(posedge clk_sys_in) {update_in, soft_reset_in, bist_done_in} <= 3'h0;
  endtask
  // Write with model update; 0x79 lands in the master until update
  task automatic wrm(input logic [6:0] a, input logic [15:0] v);
    host.wr(a, v);
    if (a == 7'h78) mdl['h78] = v;
    if (a == 7'h7E) mdl['h7E] &= ~(v & 16'hF800) & (v[11] ? 16'hFC00 : 16'hFFFF);
    if (a == 7'h79) mdl[0] = v;
  endtask
  task automatic rdc(input logic [6:0] a, input logic [15:0] m);
    host.rd(a, q);
    `CHK(q & m, 16'(mdl[a]) & m)
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    fails++;
    summarize();
  end
  // Main sequence
  initial
  begin
    {reset_in, soft_reset_in, update_in, bist_done_in} = 4'h8;
    {ch_status_in, bist_sig_in, sum_a_in, sum_b_in} = '0;
    {casc_i_a_in, casc_i_b_in, casc_q_a_in, casc_q_b_in} = '0;
    for (int a = 0; a < 128; a++) mdl[a] = 0;
    mdl['h7D] = `DCS_REVISION;
    repeat (8) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    for (int a = 'h78; a < 'h80; a++) rdc(a, a == 'h7D ? 16'h0007 : 16'hFFFF);
    wrm(7'h7A, xs());
    rdc(7'h7A, 16'hFFFF);
    wrm(7'h78, xs() & 16'hBFFF);
    rdc(7'h78, 16'hFFFF);
    wrm(7'h79, xs() | 16'h0001);
    rdc(7'h79, 16'hFFFF);
    pulse(3'h4);
    mdl['h79] = mdl[0];
    rdc(7'h79, 16'hFFFF);
    pulse(3'h2);
    mdl['h79] = 0;
    rdc(7'h79, 16'hFFFF);
    pulse(3'h4);
    mdl['h79] = mdl[0];
    rdc(7'h79, 16'hFFFF);
    $display("test registers done");
    wrm(7'h78, 16'h4000);
    rdc(7'h7D, 16'h8000);
    bist_sig_in <= 12'(xs());
    pulse(3'h1);
    mdl['h7D] = {1'b1, bist_sig_in, `DCS_REVISION};
    rdc(7'h7D, 16'hFFFF);
    wrm(7'h78, 16'h0000);
    mdl['h7D] = `DCS_REVISION;
    rdc(7'h7D, 16'h8007);
    repeat (`DCS_BIST_CYCLES) @(posedge clk_sys_in);
    mdl['h7D] = 16'h8000 | `DCS_REVISION;
    rdc(7'h7D, 16'h8007);
    $display("test selftest done");
    ch = xs() % 4;
    ch_status_in <= 64'h0100 << (16 * ch);
    @(posedge clk_sys_in) ch_status_in <= '0;
    mdl['h7E] = 16'h1000 << ch;
    rdc(7'h7E, 16'hFFFF);
    wrm(7'h7E, 16'hF000 & ~(16'h1000 << ch));
    rdc(7'h7E, 16'hFFFF);
    `CHK(clr_acc, 4'hF ^ (4'h1 << ch))
    wrm(7'h7E, 16'h1000 << ch);
    rdc(7'h7E, 16'hFFFF);
    `CHK(clr_acc, 4'h1 << ch)
    sum_a_in[39:0] <= {20'h7FFFF, 20'h80000};
    sum_b_in[39:0] <= {20'h00001, 20'h80000};
    {casc_i_a_in, casc_i_b_in, casc_q_a_in, casc_q_b_in} <= {20'h80000, 20'h80000, 20'h7FFFF, 20'h7FFFF};
    repeat (2) @(posedge clk_sys_in);
    `CHK(sum_out[39:20], 20'h7FFFF)
    `CHK(sum_out[19:0], 20'h80001)
    `CHK(casc_i_out, 20'h80001)
    `CHK(casc_q_out, 20'h7FFFF)
    {sum_a_in, sum_b_in, casc_i_a_in, casc_i_b_in, casc_q_a_in, casc_q_b_in} <= '0;
    mdl['h7E] = 16'h0B03;
    rdc(7'h7E, 16'hFFFF);
    wrm(7'h7E, 16'h0800);
    rdc(7'h7E, 16'hFFFF);
    $display("test status done");
    n = 0;
    wrm(7'h7F, 16'hFFFD);
    `CHK(n, 1)
    wrm(7'h78, xs() & 16'hBFFF);
    wrm(7'h7F, 16'h0002);
    mdl['h78] = 0;
    mdl['h79] = 0;
    pulse(3'h4);
    rdc(7'h78, 16'hFFFF);
    rdc(7'h79, 16'hFFFF);
    $display("test actions done");
    summarize();
  end
endmodule // dcs_bank_tb
